// ### irb_decoder.sv
// Serial time code decoder with its own seconds timebase.
// Assumes both inputs are synchronous to i_ref_clk; the AM input is the
// already demodulated envelope, high during mark.
`default_nettype none
module irb_decoder import irb_pkg::*; #(
  parameter int SYM_CYCLES = IRB_SYM_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_mode_am,
  input wire logic i_am_level,
  input wire logic i_dc_level,
  input wire logic [6:0] i_host_year,
  output irb_time_type o_time,
  output logic [$clog2(SYM_CYCLES * IRB_FRAME_SYMS)-1:0] o_sub_sec,
  output logic o_sec_pulse,
  output logic o_aligned,
  output logic o_locked,
  output logic o_frame_err,
  output logic o_year_from_host
);
  localparam int SEC_CYCLES = SYM_CYCLES * IRB_FRAME_SYMS;
  localparam int CW = $clog2(SEC_CYCLES);
  localparam int ONE_MIN = SYM_CYCLES * IRB_ONE_SPLIT_PCT / IRB_PCT_FULL;
  localparam int MARK_MIN = SYM_CYCLES * IRB_MARK_SPLIT_PCT / IRB_PCT_FULL;
  localparam int LOSS_CYCLES = SYM_CYCLES * IRB_LOSS_SYMS;

  logic lvl;
  logic lvl_d;
  logic rise;
  logic fall;
  logic [CW-1:0] hi_cnt;
  logic [CW-1:0] idle_cnt;
  logic lost;
  irb_sym_type kind;
  logic is_mark;
  irb_state_type state;
  logic [6:0] sym_idx;
  logic prev_mark;
  logic [IRB_FRAME_SYMS-1:0] fbits;
  logic boundary;
  logic frame_done;
  logic load;
  irb_time_type dec;
  logic [6:0] dec_yy;
  logic [6:0] dec_sec_wide;
  logic [6:0] dec_min_wide;
  logic [6:0] dec_hour_wide;
  logic dec_host;
  logic dec_ok;
  irb_time_type pend;
  logic pend_valid;

  function automatic logic mark_pos(input logic [6:0] idx);
    return (idx % IRB_MARK_STEP) == IRB_MARK_PHASE || idx == 7'h00;
  endfunction

  function automatic logic [6:0] bcd2(input logic [3:0] t,
                                      input logic [3:0] u);
    return 7'(t) * 7'(IRB_BCD_RADIX) + 7'(u);
  endfunction

  function automatic logic [8:0] year_days(input logic [11:0] y);
    return (y % IRB_LEAP_PERIOD == 0) ? IRB_DAYS_LEAP : IRB_DAYS_NORM;
  endfunction

  // One second later, with full calendar carry
  function automatic irb_time_type inc(input irb_time_type t);
    irb_time_type n;
    n = t;
    n.sec = t.sec + 6'h01;
    if (t.sec == IRB_SEC_MAX) begin
      n.sec = 6'h00;
      n.min = t.min + 6'h01;
      if (t.min == IRB_MIN_MAX) begin
        n.min = 6'h00;
        n.hour = t.hour + 5'h01;
        if (t.hour == IRB_HOUR_MAX) begin
          n.hour = 5'h00;
          n.day = t.day + 9'h001;
          // day wraps after 365 or 366
          if (t.day >= year_days(t.year)) begin
            n.day = IRB_DAY_FIRST;
            n.year = t.year + 12'h001;
          end
        end
      end
    end
    return n;
  endfunction

  // AM envelope or DC pulse width input
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lvl <= 1'b0;
      lvl_d <= 1'b0;
    end else begin
      lvl <= i_mode_am ? i_am_level : i_dc_level;
      lvl_d <= lvl;
    end
  end

  assign rise = lvl && !lvl_d;
  assign fall = !lvl && lvl_d;

  // mark time counted while input is high
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hi_cnt <= '0;
    end else if (rise) begin
      hi_cnt <= CW'(1);
    end else if (lvl && hi_cnt != CW'(SYM_CYCLES)) begin
      hi_cnt <= hi_cnt + CW'(1);
    end
  end

  // Dead input is caught here, else a stale frame could be applied late
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      idle_cnt <= '0;
    end else if (rise) begin
      idle_cnt <= '0;
    end else if (idle_cnt != CW'(LOSS_CYCLES)) begin
      idle_cnt <= idle_cnt + CW'(1);
    end
  end

  assign lost = idle_cnt == CW'(LOSS_CYCLES);

  always_comb begin
    if (hi_cnt > CW'(MARK_MIN)) begin
      kind = IRB_SYM_MARK;
    end else if (hi_cnt > CW'(ONE_MIN)) begin
      kind = IRB_SYM_ONE;
    end else begin
      kind = IRB_SYM_ZERO;
    end
  end

  assign is_mark = kind == IRB_SYM_MARK;

  // second marker of a pair is the boundary
  assign boundary = fall && is_mark && !lost &&
    ((state == IRB_HUNT && prev_mark) ||
     (state == IRB_LOCK && sym_idx == 7'(IRB_FRAME_SYMS)));
  assign frame_done = fall && is_mark && !lost && state == IRB_LOCK &&
    sym_idx == 7'(IRB_LAST_SYM);
  assign load = boundary && pend_valid;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state <= IRB_HUNT;
      o_locked <= 1'b0;
      sym_idx <= 7'h00;
      prev_mark <= 1'b0;
      fbits <= '0;
      o_frame_err <= 1'b0;
    end else if (lost) begin
      state <= IRB_HUNT;
      o_locked <= 1'b0;
      prev_mark <= 1'b0;
    end else if (fall) begin
      prev_mark <= is_mark;
      case (state)
        IRB_HUNT: begin
          if (boundary) begin
            state <= IRB_LOCK;
            o_locked <= 1'b1;
            sym_idx <= 7'h01;
          end
        end
        IRB_LOCK: begin
          if (boundary) begin
            sym_idx <= 7'h01;
          end else if (sym_idx == 7'(IRB_FRAME_SYMS) ||
                       is_mark != mark_pos(sym_idx)) begin
            state <= IRB_HUNT;
            o_locked <= 1'b0;
            o_frame_err <= 1'b1;
          end else begin
            fbits[sym_idx] <= kind == IRB_SYM_ONE;
            sym_idx <= sym_idx + 7'h01;
            if (frame_done) begin
              o_frame_err <= !dec_ok;
            end
          end
        end
        default: begin
          state <= IRB_HUNT;
          o_locked <= 1'b0;
        end
      endcase
    end
  end

  // only symbols below the control field are decoded
  // index positions are skipped by the slices below
  always_comb begin
    dec = IRB_TIME_RST;
    // Range is checked on the full value, else 64 would pass as 0
    // seconds
    dec_sec_wide = bcd2(4'(fbits[IRB_SEC_T +: 3]), fbits[IRB_SEC_U +: 4]);
    dec.sec = 6'(dec_sec_wide);
    dec_min_wide = bcd2(4'(fbits[IRB_MIN_T +: 3]), fbits[IRB_MIN_U +: 4]);
    dec.min = 6'(dec_min_wide);
    dec_hour_wide = bcd2(4'(fbits[IRB_HOUR_T +: 2]),
                         fbits[IRB_HOUR_U +: 4]);
    dec.hour = 5'(dec_hour_wide);
    dec_yy = bcd2(fbits[IRB_YEAR_T +: 4], fbits[IRB_YEAR_U +: 4]);
    // zero year means host supplies it
    dec_host = dec_yy == 7'h00;
    // years fall in 2001 to 2099 from the frame, 2000 to 2127 from the host
    dec.year = IRB_CENTURY + (dec_host ? 12'(i_host_year) : 12'(dec_yy));
    dec.day = 9'(fbits[IRB_DAY_H +: 2]) * 9'(IRB_BCD_HUND) +
      9'(bcd2(fbits[IRB_DAY_T +: 4], fbits[IRB_DAY_U +: 4]));
    // every digit and field range checked
    dec_ok = fbits[IRB_SEC_U +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_MIN_U +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_HOUR_U +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_DAY_U +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_DAY_T +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_YEAR_U +: 4] <= IRB_DIGIT_MAX &&
      fbits[IRB_YEAR_T +: 4] <= IRB_DIGIT_MAX &&
      dec_sec_wide <= 7'(IRB_SEC_MAX) && dec_min_wide <= 7'(IRB_MIN_MAX) &&
      dec_hour_wide <= 7'(IRB_HOUR_MAX) && dec.day >= IRB_DAY_FIRST &&
      // day 366 only in a leap year
      dec.day <= year_days(dec.year);
  end

  // frame held until the next boundary
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pend <= IRB_TIME_RST;
      pend_valid <= 1'b0;
      o_year_from_host <= 1'b0;
    end else if (frame_done) begin
      pend <= dec;
      pend_valid <= dec_ok;
      if (dec_ok) begin
        o_year_from_host <= dec_host;
      end
    end else if (load || state == IRB_HUNT) begin
      pend_valid <= 1'b0;
    end
  end

  // timebase realigned on a good boundary
  // Sub-second restarts at the elapsed mark time, i.e. from the edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_time <= IRB_TIME_RST;
      o_sub_sec <= '0;
      o_sec_pulse <= 1'b0;
      o_aligned <= 1'b0;
    end else begin
      o_sec_pulse <= 1'b0;
      o_aligned <= 1'b0;
      if (load) begin
        // year loaded too, from i_host_year when the frame's year is 00
        o_time <= inc(pend);
        o_sub_sec <= hi_cnt;
        o_aligned <= 1'b1;
      end else if (o_sub_sec == CW'(SEC_CYCLES - 1)) begin
        o_sub_sec <= '0;
        o_time <= inc(o_time);
        o_sec_pulse <= 1'b1;
      end else begin
        o_sub_sec <= o_sub_sec + CW'(1);
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_zero_class: assert property (
    fall && !lost && state == IRB_LOCK && sym_idx < 7'(IRB_FRAME_SYMS) &&
    !boundary && hi_cnt <= CW'(ONE_MIN) && !mark_pos(sym_idx)
    |=> !fbits[$past(sym_idx)])
    else $error("short mark not stored as zero");
  a_high_count: assert property (
    lvl && lvl_d && $past(lvl_d) && $past(hi_cnt) < CW'(SYM_CYCLES)
    |-> hi_cnt == $past(hi_cnt) + CW'(1))
    else $error("mark time not counted");
  a_sec_tick: assert property (
    o_sub_sec == CW'(SEC_CYCLES - 1) && !load
    |=> o_sec_pulse && o_sub_sec == '0 && o_time == inc($past(o_time)))
    else $error("second rollover wrong");
  a_boundary_lock: assert property (
    boundary |=> state == IRB_LOCK && o_locked && sym_idx == 7'h01)
    else $error("boundary did not start a frame");
  a_marker_miss: assert property (
    fall && !lost && state == IRB_LOCK && sym_idx < 7'(IRB_FRAME_SYMS) &&
    is_mark != mark_pos(sym_idx)
    |=> state == IRB_HUNT && o_frame_err && !o_locked)
    else $error("misplaced marker not rejected");
  a_time_range: assert property (
    o_time.sec <= IRB_SEC_MAX && o_time.min <= IRB_MIN_MAX &&
    o_time.hour <= IRB_HOUR_MAX && o_time.day >= IRB_DAY_FIRST)
    else $error("timebase field out of range");
  a_century_year: assert property (
    o_time.year >= IRB_CENTURY)
    else $error("year before the century");
  a_host_year: assert property (
    frame_done && dec_ok && dec_host |=> o_year_from_host)
    else $error("zero year not flagged");
  a_bad_skip: assert property (
    frame_done && !dec_ok |=> !pend_valid && o_frame_err ##1 !o_aligned)
    else $error("bad frame not skipped");
  a_align_load: assert property (
    load |=> o_aligned && o_time == inc($past(pend)) ##1 !o_aligned)
    else $error("aligned time not frame plus one");

  c_lock: cover property (state == IRB_HUNT ##1 state == IRB_LOCK);
  c_align: cover property (o_aligned);
  c_err: cover property (frame_done && !dec_ok);
  c_host: cover property (load && o_year_from_host);
endmodule
`default_nettype wire

// ### irb_decoder_tb.sv
// Self-checking bench for the time code decoder and its timebase.
// Assumes a shortened symbol, so one second is 5000 clock cycles.
`default_nettype none
module irb_decoder_tb import irb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SYMC = 50;
  localparam int SEC = SYMC * IRB_FRAME_SYMS;
  logic clk;
  logic rst;
  logic mode_am;
  logic src_level;
  logic am_in;
  logic dc_in;
  logic bad_mark;
  logic [6:0] host_year;
  irb_time_type src_time;
  irb_time_type t_out;
  irb_time_type exp_t;
  logic [$clog2(SEC)-1:0] sub_sec;
  logic sec_pulse;
  logic aligned;
  logic locked;
  logic frame_err;
  logic yfh;
  logic [2:0] evs;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Unselected line carries the inverse, so reading it shows up at once
  assign am_in = mode_am ? src_level : ~src_level;
  assign dc_in = mode_am ? ~src_level : src_level;
  assign evs = {frame_err, sec_pulse, aligned};
  irb_decoder #(.SYM_CYCLES(SYMC)) irb_decoder_i (
    .i_ref_clk(clk),
    .i_sys_rst(rst),
    .i_mode_am(mode_am),
    .i_am_level(am_in),
    .i_dc_level(dc_in),
    .i_host_year(host_year),
    .o_time(t_out),
    .o_sub_sec(sub_sec),
    .o_sec_pulse(sec_pulse),
    .o_aligned(aligned),
    .o_locked(locked),
    .o_frame_err(frame_err),
    .o_year_from_host(yfh)
  );
  irb_src #(.SYM_CYCLES(SYMC)) irb_src_i (
    .i_ref_clk(clk),
    .i_sys_rst(rst),
    .i_time(src_time),
    .i_bad_mark(bad_mark),
    .o_level(src_level)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Seven seconds of traffic need about 35000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      $display("CHECK FAILED %0t run timed out", $time);
      print_verdict();
    end
  end
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_time(input irb_time_type got, input irb_time_type exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t time got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Which: 0 aligned, 1 second pulse, 2 frame error
  task automatic wait_ev(input int which, input int limit);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (evs[which] !== 1'b1 && n < limit);
    cmp_val(32'(evs[which]), 32'h1, "event seen");
  endtask
  function automatic irb_time_type inc_sec(irb_time_type t);
    irb_time_type r;
    logic [8:0] last;
    r = t;
    last = (t.year % 4 == 0) ? IRB_DAYS_LEAP : IRB_DAYS_NORM;
    r.sec = t.sec + 6'h01;
    if (t.sec == IRB_SEC_MAX) begin
      r.sec = 6'h00;
      r.min = t.min + 6'h01;
      if (t.min == IRB_MIN_MAX) begin
        r.min = 6'h00;
        r.hour = t.hour + 5'h01;
        if (t.hour == IRB_HOUR_MAX) begin
          r.hour = 5'h00;
          r.day = (t.day == last) ? IRB_DAY_FIRST : t.day + 9'h001;
          if (t.day == last) r.year = t.year + 12'h001;
        end
      end
    end
    return r;
  endfunction
  task automatic check_aligned(input irb_time_type exp, input logic e_yfh);
    wait_ev(0, 4 * SEC);
    cmp_time(t_out, exp);
    cmp_val(32'(sub_sec), SYMC * IRB_MARK_PCT / IRB_PCT_FULL, "sub");
    cmp_val(32'(locked), 32'h1, "locked");
    cmp_val(32'(frame_err), 32'h0, "error flag");
    cmp_val(32'(yfh), 32'(e_yfh), "host year flag");
  endtask
  initial begin
    rst = 1'b1;
    mode_am = 1'b0;
    bad_mark = 1'b0;
    host_year = 7'h1C;
    src_time = '{12'h7E8, 9'h16E, 5'h17, 6'h3B, 6'h3B};
    repeat (6) @(negedge clk);
    cmp_time(t_out, IRB_TIME_RST);
    cmp_val(32'({sub_sec, evs, locked, yfh}), 32'h0, "reset flags");
    rst = 1'b0;
    // Leap day 366 at the last second rolls into a new year
    exp_t = inc_sec(src_time);
    check_aligned(exp_t, 1'b0);
    src_time = '{12'h7D0, 9'h16E, 5'h0C, 6'h22, 6'h38};
    wait_ev(1, 2 * SEC);
    cmp_time(t_out, inc_sec(exp_t));
    // Year 00 takes 28 from the host; day 366 is legal there
    check_aligned('{12'h7EC, 9'h16E, 5'h0C, 6'h22, 6'h39}, 1'b1);
    src_time = '{12'h7EF, 9'h064, 5'h0A, 6'h3C, 6'h00};
    wait_ev(2, 2 * SEC);
    mode_am = 1'b1;
    src_time = '{12'h7EF, 9'h03B, 5'h09, 6'h08, 6'h07};
    // Bad frame must not load; next good one comes via the AM path
    check_aligned('{12'h7EF, 9'h03B, 5'h09, 6'h08, 6'h08}, 1'b0);
    bad_mark = 1'b1;
    wait_ev(2, 2 * SEC);
    @(negedge clk);
    cmp_val(32'(locked), 32'h0, "lock after lost marker");
    bad_mark = 1'b0;
    src_time = '{12'h832, 9'h16D, 5'h17, 6'h3B, 6'h3B};
    check_aligned('{12'h833, 9'h001, 5'h00, 6'h00, 6'h00}, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### irb_pkg.sv
// Constants, types and timing figures for the serial time code decoder.
// Assumes a 125 MHz reference clock and a digital mark/space input.
`default_nettype none
package irb_pkg;
  localparam int IRB_CLK_HZ = 125_000_000;
  localparam int IRB_HZ_PER_MHZ = 1_000_000;
  localparam int IRB_SYM_PERIOD_US = 10_000;
  localparam int IRB_SYM_CYCLES =
    IRB_CLK_HZ / IRB_HZ_PER_MHZ * IRB_SYM_PERIOD_US;
  localparam int IRB_FRAME_SYMS = 100;
  localparam int IRB_LAST_SYM = IRB_FRAME_SYMS - 1;
  localparam int IRB_LOSS_SYMS = 2;
  localparam int IRB_PCT_FULL = 100;
  localparam int IRB_ZERO_PCT = 20;
  localparam int IRB_ONE_PCT = 50;
  localparam int IRB_MARK_PCT = 80;
  localparam int IRB_ONE_SPLIT_PCT = (IRB_ZERO_PCT + IRB_ONE_PCT) / 2;
  localparam int IRB_MARK_SPLIT_PCT = (IRB_ONE_PCT + IRB_MARK_PCT) / 2;
  localparam int IRB_MARK_STEP = 10;
  localparam int IRB_MARK_PHASE = 9;
  localparam int IRB_SEC_U = 1;
  localparam int IRB_SEC_T = 6;
  localparam int IRB_MIN_U = 10;
  localparam int IRB_MIN_T = 15;
  localparam int IRB_HOUR_U = 20;
  localparam int IRB_HOUR_T = 25;
  localparam int IRB_DAY_U = 30;
  localparam int IRB_DAY_T = 35;
  localparam int IRB_DAY_H = 40;
  localparam int IRB_YEAR_U = 50;
  localparam int IRB_YEAR_T = 55;
  localparam int IRB_BCD_RADIX = 10;
  localparam int IRB_BCD_HUND = 100;
  localparam int IRB_LEAP_PERIOD = 4;
  localparam logic [3:0] IRB_DIGIT_MAX = 4'h9;
  localparam logic [5:0] IRB_SEC_MAX = 6'h3B;
  localparam logic [5:0] IRB_MIN_MAX = 6'h3B;
  localparam logic [4:0] IRB_HOUR_MAX = 5'h17;
  localparam logic [8:0] IRB_DAY_FIRST = 9'h001;
  localparam logic [8:0] IRB_DAYS_NORM = 9'h16D;
  localparam logic [8:0] IRB_DAYS_LEAP = 9'h16E;
  localparam logic [11:0] IRB_CENTURY = 12'h7D0;
  typedef struct packed {
    logic [11:0] year;
    logic [8:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } irb_time_type;
  localparam irb_time_type IRB_TIME_RST =
    '{IRB_CENTURY, IRB_DAY_FIRST, 5'h00, 6'h00, 6'h00};
  typedef enum logic {IRB_HUNT, IRB_LOCK} irb_state_type;
  typedef enum logic [1:0] {IRB_SYM_ZERO, IRB_SYM_ONE, IRB_SYM_MARK}
    irb_sym_type;
endpackage
`default_nettype wire

// ### irb_src.sv
// Behavioural time code source: one frame per second, forever.
// Assumes the bench edits i_time only between a boundary and symbol 1.
`default_nettype none
module irb_src import irb_pkg::*; #(
  parameter int SYM_CYCLES = 100
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire irb_time_type i_time,
  input wire logic i_bad_mark,
  output logic o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [99:0] bits;
  logic mark;
  int hi;
  function automatic logic [99:0] pack_frame(irb_time_type t);
    logic [99:0] b;
    int y;
    b = '0;
    y = int'(t.year) - 2000;
    b[1+:4] = 4'(t.sec % 10);
    b[6+:3] = 3'(t.sec / 10);
    b[10+:4] = 4'(t.min % 10);
    b[15+:3] = 3'(t.min / 10);
    b[20+:4] = 4'(t.hour % 10);
    b[25+:2] = 2'(t.hour / 10);
    b[30+:4] = 4'(t.day % 10);
    b[35+:4] = 4'(t.day / 10 % 10);
    b[40+:2] = 2'(t.day / 100);
    b[50+:4] = 4'(y % 10);
    b[55+:4] = 4'(y / 10);
    // busy filler that must not disturb decoding
    b[60+:9] = 9'h1A5;
    b[70+:9] = 9'h0DB;
    b[80+:9] = 9'h16C;
    b[90+:8] = 8'hB7;
    return b;
  endfunction
  initial begin
    o_level = 1'b0;
    bits = '0;
    // Reset looked at on the rising edge, clear of the bench's negedge writes
    while (i_sys_rst !== 1'b0) @(posedge i_ref_clk);
    forever begin
      for (int s = 0; s < IRB_FRAME_SYMS; s++) begin
        if (s == 1) bits = pack_frame(i_time);
        // markers at 0 and 9, 19 ... 99; the one at 9 is dropped while i_bad_mark is high
        mark = (s == 0) || (s % 10 == 9 && !(i_bad_mark && s == 9));
        hi = mark ? IRB_MARK_PCT : (bits[s] ? IRB_ONE_PCT : IRB_ZERO_PCT);
        for (int c = 0; c < SYM_CYCLES; c++) begin
          @(negedge i_ref_clk);
          o_level = (c < hi * SYM_CYCLES / IRB_PCT_FULL);
        end
      end
    end
  end
endmodule
`default_nettype wire
